/* include/rdlrs_params.svh */
// Constants for the receive data link route select block
`ifndef RDLRS_PARAMS_SVH
`define RDLRS_PARAMS_SVH

// ****************************************************************
// Register map and fields
// ****************************************************************
`define RDLRS_ADDR_W        12
`define RDLRS_OFS_SELECT    12'h10C
`define RDLRS_OFS_STATUS    12'h110
`define RDLRS_SEL_RESET     8'h00
`define RDLRS_BW_LSB        4
`define RDLRS_DE_LSB        2
`define RDLRS_DL_LSB        0
`define RDLRS_SEL_MASK      8'h3F
`define RDLRS_FRAME_MOD_W   2
`define RDLRS_ODD_PHASE     2'h0
`define RDLRS_EVEN_PHASE    2'h2
`define RDLRS_FIFO_W        3
`define RDLRS_FIFO_D        8

`endif

/* include/rdlrs_pkg.sv */
// Types for the receive data link route select block
package rdlrs_pkg;
	typedef enum logic [1:0] {
		RDLRS_BW_4K   = 2'h0,
		RDLRS_BW_ODD  = 2'h1,
		RDLRS_BW_EVEN = 2'h2,
		RDLRS_BW_RSV  = 2'h3
	} rdlrs_bw_e;
	typedef enum logic [1:0] {
		RDLRS_DE_SER  = 2'h0,
		RDLRS_DE_LAPD = 2'h1,
		RDLRS_DE_RSV  = 2'h2,
		RDLRS_DE_FRAC = 2'h3
	} rdlrs_de_e;
	typedef enum logic [1:0] {
		RDLRS_DL_LAPD = 2'h0,
		RDLRS_DL_RSV  = 2'h1,
		RDLRS_DL_OH   = 2'h2,
		RDLRS_DL_ONES = 2'h3
	} rdlrs_dl_e;
	typedef enum logic [3:0] {
		RDLRS_FMT_ESF  = 4'h1,
		RDLRS_FMT_SLC  = 4'h2,
		RDLRS_FMT_N    = 4'h4,
		RDLRS_FMT_T1DM = 4'h8
	} rdlrs_fmt_e;
	typedef enum logic [1:0] {
		RDLRS_ST_IDLE = 2'h1,
		RDLRS_ST_ACK  = 2'h2
	} rdlrs_st_e;
endpackage : rdlrs_pkg

/* core/rdlrs_fifo.sv */
// Small synchronous FIFO with valid and ready on both sides
`timescale 1ns/1ns
module rdlrs_fifo #(
	parameter int W = 3,
	parameter int D = 8
) (
	input  wire logic         clk_i,    // Core clock
	input  wire logic         rst_n_i,  // Async reset, low
	input  wire logic [W-1:0] in_data_i, // Write data
	input  wire logic         in_valid_i, // Write request
	output logic              in_ready_o, // Not full
	output logic [W-1:0]      out_data_o, // Head word
	output logic              out_valid_o, // Not empty
	input  wire logic         out_ready_i  // Drain accept
);
	localparam int AW = $clog2(D);
	logic [W-1:0] mem [D];
	logic [AW-1:0] wr_ptr_ff;
	logic [AW-1:0] rd_ptr_ff;
	logic [AW:0]   count_ff;
	logic          push;
	logic          pop;

	// Handshakes; full and empty come straight from the count
	assign in_ready_o  = (count_ff != (AW+1)'(D)) ? 1'b1 : 1'b0;
	assign out_valid_o = (count_ff != '0);
	assign push        = in_valid_i && in_ready_o;
	assign pop         = out_valid_o && out_ready_i;
	assign out_data_o  = mem[rd_ptr_ff];

	// Storage, no reset needed on data
	always_ff @(posedge clk_i) begin
		if (push) begin
			mem[wr_ptr_ff] <= in_data_i;
		end
	end

	// Pointers and fill level
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			wr_ptr_ff <= '0;
			rd_ptr_ff <= '0;
			count_ff  <= '0;
		end else begin
			if (push) begin
				wr_ptr_ff <= (wr_ptr_ff == AW'(D-1)) ? '0 : wr_ptr_ff + 1'b1;
			end
			if (pop) begin
				rd_ptr_ff <= (rd_ptr_ff == AW'(D-1)) ? '0 : rd_ptr_ff + 1'b1;
			end
			if (push && !pop) begin
				count_ff <= count_ff + 1'b1;
			end else if (pop && !push) begin
				count_ff <= count_ff - 1'b1;
			end
		end
	end

	a_fifo_no_overflow : assert property (@(posedge clk_i) disable iff (!rst_n_i)
		count_ff <= (AW+1)'(D))
		else $error("fifo count above depth");
endmodule : rdlrs_fifo

/* core/rdlrs_top.sv */
// Receive data link and D/E slot route select with Wishbone register access
//
// The Wishbone register port was left to the implementer.
`timescale 1ns/1ns
`include "rdlrs_params.svh"
module rdlrs_top (
	input  wire logic                     CORE_CLK_I,      // 250 MHz core clock
	input  wire logic                     RESETN_I,        // Async reset, low
	input  wire logic                     WB_CYC_I,        // Wishbone cycle
	input  wire logic                     WB_STB_I,        // Wishbone strobe
	input  wire logic                     WB_WE_I,         // Write enable
	input  wire logic [`RDLRS_ADDR_W-1:0] WB_ADR_I,        // Byte address
	input  wire logic [3:0]               WB_SEL_I,        // Byte lanes
	input  wire logic [31:0]              WB_DAT_I,        // Write data
	output logic      [31:0]              WB_DAT_O,        // Read data
	output logic                          WB_ACK_O,        // Acknowledge
	input  wire rdlrs_pkg::rdlrs_fmt_e    FRAME_FMT_I,     // Framing format, one-hot
	input  wire logic                     BIT_VALID_I,     // One rx bit this cycle
	input  wire logic                     BIT_DATA_I,      // Received bit
	input  wire logic                     BIT_IS_DL_I,     // Bit is a link bit
	input  wire logic                     BIT_IS_DE_I,     // Bit is in a D/E slot
	input  wire logic                     FRAME_START_I,   // First bit of a frame
	input  wire logic                     MFRAME_START_I,  // First frame of multiframe
	output logic                          RX_SERIAL_OUT_O, // Serial receive data
	output logic                          RX_SERIAL_EN_O,  // Serial bit valid
	output logic                          RX_FRACTIONAL_OUT_O, // Fractional data
	output logic                          RX_FRACTIONAL_EN_O,  // Fractional valid
	output logic                          RX_OVERHEAD_OUT_O,   // Overhead data
	output logic                          RX_OVERHEAD_EN_O,    // Overhead valid
	output logic                          LAPD1_DATA_O,    // LAPD controller one data
	output logic                          LAPD1_VALID_O,   // LAPD one data valid
	input  wire logic                     LAPD1_READY_I,   // LAPD one accepts
	output logic                          LAPD1_IS_DL_O,   // Word came from link bits
	output logic                          LAPD1_IS_DE_O,   // Word came from D/E slot
	output logic                          LAPD_OTHER_VALID_O // Other controllers, never set
);
	import rdlrs_pkg::*;

	// ****************************************************************
	// Register bank and Wishbone slave
	// ****************************************************************
	logic [7:0]  select_ff;
	rdlrs_st_e   bus_st_ff;
	logic        bus_req;
	logic        hit_select;
	logic        hit_status;
	logic [7:0]  frame_cnt_ff;
	logic [15:0] lapd_drop_ff;
	logic        fifo_in_ready;
	logic        fifo_out_valid;
	logic [2:0]  fifo_out_data;
	rdlrs_bw_e   bw_sel;
	rdlrs_de_e   de_sel;
	rdlrs_dl_e   dl_sel;

	assign bus_req    = WB_CYC_I && WB_STB_I && (bus_st_ff == RDLRS_ST_IDLE);
	assign hit_select = (WB_ADR_I == `RDLRS_OFS_SELECT);
	assign hit_status = (WB_ADR_I == `RDLRS_OFS_STATUS);

	// Bus state: answer one cycle after the request, then drop ack
	always_ff @(posedge CORE_CLK_I or negedge RESETN_I) begin
		if (!RESETN_I) begin
			bus_st_ff <= RDLRS_ST_IDLE;
		end else begin
			unique case (bus_st_ff)
				RDLRS_ST_IDLE: begin
					if (bus_req) begin
						bus_st_ff <= RDLRS_ST_ACK;
					end
				end
				RDLRS_ST_ACK: begin
					bus_st_ff <= RDLRS_ST_IDLE;
				end
				default: begin
					bus_st_ff <= RDLRS_ST_IDLE;
				end
			endcase
		end
	end

	// Ack and read data registered so outputs come from flops
	always_ff @(posedge CORE_CLK_I or negedge RESETN_I) begin
		if (!RESETN_I) begin
			WB_ACK_O <= 1'b0;
			WB_DAT_O <= 32'h00000000;
		end else begin
			WB_ACK_O <= bus_req;
			if (bus_req && !WB_WE_I) begin
				if (hit_select) begin
					WB_DAT_O <= {24'h000000, select_ff};
				end else if (hit_status) begin
					WB_DAT_O <= {lapd_drop_ff, frame_cnt_ff, 5'h00, fifo_in_ready,
						fifo_out_valid, 1'b0};
				end else begin
					WB_DAT_O <= 32'h00000000; // Unmapped reads return zero
				end
			end
		end
	end

	// Select register; bits 7:6 are reserved and stay zero
	always_ff @(posedge CORE_CLK_I or negedge RESETN_I) begin
		if (!RESETN_I) begin
			select_ff <= `RDLRS_SEL_RESET;
		end else if (bus_req && WB_WE_I && hit_select && WB_SEL_I[0]) begin
			select_ff <= WB_DAT_I[7:0] & `RDLRS_SEL_MASK;
		end
	end

	// ****************************************************************
	// Field decode with reserved-code fallback
	// ****************************************************************
	// Reserved codes map to the reset routing so a bad write cannot strand data
	always_comb begin
		bw_sel = rdlrs_bw_e'(select_ff[`RDLRS_BW_LSB +: 2]);
		de_sel = rdlrs_de_e'(select_ff[`RDLRS_DE_LSB +: 2]);
		dl_sel = rdlrs_dl_e'(select_ff[`RDLRS_DL_LSB +: 2]);
		if (bw_sel == RDLRS_BW_RSV) begin
			bw_sel = RDLRS_BW_4K;
		end
		if (de_sel == RDLRS_DE_RSV) begin
			de_sel = RDLRS_DE_SER;
		end
		if (dl_sel == RDLRS_DL_RSV) begin
			dl_sel = RDLRS_DL_LAPD;
		end
	end

	// ****************************************************************
	// Frame position and link bit extraction
	// ****************************************************************
	logic frame_ok;
	logic dl_take;
	logic dl_bit;

	logic [7:0] frame_now;

	// Position including this edge's step; the framing bit rides on frame start
	always_comb begin
		frame_now = frame_cnt_ff;
		if (BIT_VALID_I && FRAME_START_I) begin
			frame_now = MFRAME_START_I ? 8'h00 : frame_cnt_ff + 8'h01;
		end
	end

	// Frame counter, zero in frame 1 of the multiframe
	always_ff @(posedge CORE_CLK_I or negedge RESETN_I) begin
		if (!RESETN_I) begin
			frame_cnt_ff <= 8'h00;
		end else begin
			frame_cnt_ff <= frame_now;
		end
	end

	// Link bits sit in odd frames; 01 keeps frames 1,5,9 and 10 frames 3,7,11
	always_comb begin
		frame_ok = 1'b1;
		if (FRAME_FMT_I == RDLRS_FMT_ESF) begin
			unique case (bw_sel)
				RDLRS_BW_ODD:  frame_ok = (frame_now[1:0] == `RDLRS_ODD_PHASE);
				RDLRS_BW_EVEN: frame_ok = (frame_now[1:0] == `RDLRS_EVEN_PHASE);
				default:       frame_ok = 1'b1;
			endcase
		end
		// SLC96, N and T1DM ignore the bandwidth code; the framer marks their link bits
		dl_take = BIT_VALID_I && BIT_IS_DL_I && frame_ok;
		dl_bit  = (dl_sel == RDLRS_DL_ONES) ? 1'b1 : BIT_DATA_I;
	end

	// ****************************************************************
	// Output steering
	// ****************************************************************
	logic fifo_push;
	logic [2:0] fifo_word;
	logic lapd_want;

	// Link bits to LAPD one when the link code selects LAPD; D/E slot bits when steered there
	always_comb begin
		lapd_want = 1'b0;
		fifo_word = {1'b0, 1'b0, BIT_DATA_I};
		if (dl_take && (dl_sel == RDLRS_DL_LAPD)) begin
			lapd_want = 1'b1;
			fifo_word = {1'b1, 1'b0, BIT_DATA_I};
		end else if (BIT_VALID_I && BIT_IS_DE_I && de_sel == RDLRS_DE_LAPD) begin
			lapd_want = 1'b1;
			fifo_word = {1'b0, 1'b1, BIT_DATA_I};
		end
		fifo_push = lapd_want && fifo_in_ready;
	end

	// Count bits lost while the LAPD buffer is full
	always_ff @(posedge CORE_CLK_I or negedge RESETN_I) begin
		if (!RESETN_I) begin
			lapd_drop_ff <= 16'h0000;
		end else if (lapd_want && !fifo_in_ready && lapd_drop_ff != 16'hFFFF) begin
			lapd_drop_ff <= lapd_drop_ff + 16'h0001;
		end
	end

	// Pin outputs, registered
	always_ff @(posedge CORE_CLK_I or negedge RESETN_I) begin
		if (!RESETN_I) begin
			RX_SERIAL_OUT_O     <= 1'b0;
			RX_SERIAL_EN_O      <= 1'b0;
			RX_FRACTIONAL_OUT_O <= 1'b0;
			RX_FRACTIONAL_EN_O  <= 1'b0;
			RX_OVERHEAD_OUT_O   <= 1'b0;
			RX_OVERHEAD_EN_O    <= 1'b0;
		end else begin
			RX_SERIAL_EN_O      <= 1'b0;
			RX_FRACTIONAL_EN_O  <= 1'b0;
			RX_OVERHEAD_EN_O    <= 1'b0;
			if (dl_take) begin
				RX_SERIAL_OUT_O <= dl_bit;
				RX_SERIAL_EN_O  <= 1'b1;
				if (dl_sel == RDLRS_DL_OH) begin
					RX_OVERHEAD_OUT_O <= dl_bit;
					RX_OVERHEAD_EN_O  <= 1'b1;
				end
			end else if (BIT_VALID_I && BIT_IS_DE_I) begin
				if (de_sel == RDLRS_DE_SER) begin
					RX_SERIAL_OUT_O <= BIT_DATA_I;
					RX_SERIAL_EN_O  <= 1'b1;
				end else if (de_sel == RDLRS_DE_FRAC) begin
					RX_FRACTIONAL_OUT_O <= BIT_DATA_I;
					RX_FRACTIONAL_EN_O  <= 1'b1;
				end
			end else if (BIT_VALID_I && !BIT_IS_DL_I) begin
				RX_SERIAL_OUT_O <= BIT_DATA_I; // Payload passes through
				RX_SERIAL_EN_O  <= 1'b1;
			end
		end
	end

	// ****************************************************************
	// LAPD buffer
	// ****************************************************************
	// Buffer lets the controller stall without losing bits up to the depth
	rdlrs_fifo #(.W(`RDLRS_FIFO_W), .D(`RDLRS_FIFO_D)) u_lapd_fifo (
		.clk_i       (CORE_CLK_I),
		.rst_n_i     (RESETN_I),
		.in_data_i   (fifo_word),
		.in_valid_i  (fifo_push),
		.in_ready_o  (fifo_in_ready),
		.out_data_o  (fifo_out_data),
		.out_valid_o (fifo_out_valid),
		.out_ready_i (!LAPD1_VALID_O || LAPD1_READY_I)
	);

	// Output stage register toward LAPD controller one
	always_ff @(posedge CORE_CLK_I or negedge RESETN_I) begin
		if (!RESETN_I) begin
			LAPD1_VALID_O      <= 1'b0;
			LAPD1_DATA_O       <= 1'b0;
			LAPD1_IS_DL_O      <= 1'b0;
			LAPD1_IS_DE_O      <= 1'b0;
			LAPD_OTHER_VALID_O <= 1'b0;
		end else if (!LAPD1_VALID_O || LAPD1_READY_I) begin
			LAPD1_VALID_O <= fifo_out_valid;
			LAPD1_DATA_O  <= fifo_out_data[0];
			LAPD1_IS_DE_O <= fifo_out_data[1];
			LAPD1_IS_DL_O <= fifo_out_data[2];
		end
	end

	// ****************************************************************
	// Assertions
	// ****************************************************************
	a_ones_forced : assert property (@(posedge CORE_CLK_I) disable iff (!RESETN_I)
		dl_take && dl_sel == RDLRS_DL_ONES |=> RX_SERIAL_EN_O && RX_SERIAL_OUT_O)
		else $error("forced ones missing");
	a_odd_frames : assert property (@(posedge CORE_CLK_I) disable iff (!RESETN_I)
		FRAME_FMT_I == RDLRS_FMT_ESF && bw_sel == RDLRS_BW_ODD && dl_take
		|-> frame_now[1:0] == `RDLRS_ODD_PHASE)
		else $error("odd bandwidth took wrong frame");
	a_even_frames : assert property (@(posedge CORE_CLK_I) disable iff (!RESETN_I)
		FRAME_FMT_I == RDLRS_FMT_ESF && bw_sel == RDLRS_BW_EVEN && dl_take
		|-> frame_now[1:0] == `RDLRS_EVEN_PHASE)
		else $error("even bandwidth took wrong frame");
	a_full_rate : assert property (@(posedge CORE_CLK_I) disable iff (!RESETN_I)
		BIT_VALID_I && BIT_IS_DL_I && bw_sel == RDLRS_BW_4K |=> RX_SERIAL_EN_O)
		else $error("4k link bit dropped");
	a_non_esf_rate : assert property (@(posedge CORE_CLK_I) disable iff (!RESETN_I)
		BIT_VALID_I && BIT_IS_DL_I && FRAME_FMT_I != RDLRS_FMT_ESF |-> dl_take)
		else $error("non ESF link bit dropped");
	a_de_serial : assert property (@(posedge CORE_CLK_I) disable iff (!RESETN_I)
		BIT_VALID_I && BIT_IS_DE_I && !BIT_IS_DL_I && select_ff[3:2] == 2'h0
		|=> RX_SERIAL_EN_O && RX_SERIAL_OUT_O == $past(BIT_DATA_I))
		else $error("D/E bit not on serial output");
	a_de_lapd : assert property (@(posedge CORE_CLK_I) disable iff (!RESETN_I)
		BIT_VALID_I && BIT_IS_DE_I && !BIT_IS_DL_I && de_sel == RDLRS_DE_LAPD
		|=> !RX_SERIAL_EN_O && !RX_FRACTIONAL_EN_O)
		else $error("D/E bit leaked to pins");
	a_de_frac : assert property (@(posedge CORE_CLK_I) disable iff (!RESETN_I)
		BIT_VALID_I && BIT_IS_DE_I && !BIT_IS_DL_I && de_sel == RDLRS_DE_FRAC
		|=> RX_FRACTIONAL_EN_O && !RX_SERIAL_EN_O)
		else $error("D/E bit not on fractional output");
	a_dl_lapd : assert property (@(posedge CORE_CLK_I) disable iff (!RESETN_I)
		dl_take && dl_sel == RDLRS_DL_LAPD && fifo_in_ready |=> fifo_out_valid)
		else $error("link bit missed LAPD buffer");
	a_other_idle : assert property (@(posedge CORE_CLK_I) disable iff (!RESETN_I)
		!LAPD_OTHER_VALID_O)
		else $error("other LAPD controller got data");
	a_dl_overhead : assert property (@(posedge CORE_CLK_I) disable iff (!RESETN_I)
		dl_take && dl_sel == RDLRS_DL_OH |=> RX_OVERHEAD_EN_O && RX_SERIAL_EN_O)
		else $error("link bit missed overhead output");
	a_reserved_fb : assert property (@(posedge CORE_CLK_I) disable iff (!RESETN_I)
		select_ff[1:0] == 2'h1 |-> dl_sel == RDLRS_DL_LAPD)
		else $error("reserved link code not defaulted");
	c_odd_take : cover property (@(posedge CORE_CLK_I) bw_sel == RDLRS_BW_ODD && dl_take);
	c_overhead : cover property (@(posedge CORE_CLK_I) RX_OVERHEAD_EN_O);
	c_lapd_full : cover property (@(posedge CORE_CLK_I) lapd_want && !fifo_in_ready);
	c_de_frac : cover property (@(posedge CORE_CLK_I) RX_FRACTIONAL_EN_O);
endmodule : rdlrs_top

/* testbench/rdlrs_lapd_model.sv */
// Model of LAPD controller one, the sink of the link word stream
`timescale 1ns/1ns
module rdlrs_lapd_model (
	input  wire logic clk_i,   // Core clock
	input  wire logic rst_n_i, // Async reset, low
	input  wire logic data_i,  // Word bit
	input  wire logic valid_i, // Word offered
	input  wire logic is_dl_i, // Word came from link bits
	input  wire logic is_de_i, // Word came from a D/E slot
	input  wire logic stall_i, // Bench holds the sink off
	output logic      ready_o  // Sink accepts
);
	// ****************************************************************
	// Word sink
	// ****************************************************************
	logic [2:0] got[$]; // Words taken, {dl, de, data}
	// Ready drops only while stalled, so the block must hold its word
	assign ready_o = !stall_i;
	// A word counts only at the edge where valid meets ready
	always @(posedge clk_i) begin
		if (rst_n_i && valid_i && ready_o) begin
			got.push_back({is_dl_i, is_de_i, data_i});
		end
	end
endmodule : rdlrs_lapd_model

/* testbench/test_rdlrs_top.sv */
// Self-checking bench for the receive link and D/E slot route select
`timescale 1ns/1ns
`include "rdlrs_params.svh"
`define CHK(g, e) begin cmp_count++; if ((g) !== (e)) begin bad_count++; \
	$display("mismatch at %0t: got %h exp %h", $time, (g), (e)); end end
module test_rdlrs_top;
	import rdlrs_pkg::*;
	// ****************************************************************
	// Signals, clock and monitors
	// ****************************************************************
	logic        clk = 1'b0, rst_n = 1'b0, cyc = 1'b0, stb = 1'b0, we = 1'b0;
	logic [11:0] adr = 12'h000;
	logic [3:0]  sel = 4'hF;
	logic [31:0] wdat = 32'h0, rdat;
	logic        ack, bv = 1'b0, bd = 1'b0, bdl = 1'b0, bde = 1'b0;
	logic        fs = 1'b0, ms = 1'b0, stall = 1'b0, l_rdy, l_oth;
	logic        ser, ser_en, frac, frac_en, oh, oh_en, l_d, l_v, l_dl, l_de;
	logic        ser_last = 1'b0, oth_seen = 1'b0;
	rdlrs_fmt_e  fmt = RDLRS_FMT_ESF;
	int          ser_cnt = 0, oh_cnt = 0, frac_cnt = 0, oh_ones = 0, frac_ones = 0;
	int          bad_count = 0, cmp_count = 0, cyc_cnt = 0;
	rdlrs_top uut (.CORE_CLK_I(clk), .RESETN_I(rst_n), .WB_CYC_I(cyc), .WB_STB_I(stb),
		.WB_WE_I(we), .WB_ADR_I(adr), .WB_SEL_I(sel), .WB_DAT_I(wdat), .WB_DAT_O(rdat),
		.WB_ACK_O(ack), .FRAME_FMT_I(fmt), .BIT_VALID_I(bv), .BIT_DATA_I(bd),
		.BIT_IS_DL_I(bdl), .BIT_IS_DE_I(bde), .FRAME_START_I(fs), .MFRAME_START_I(ms),
		.RX_SERIAL_OUT_O(ser), .RX_SERIAL_EN_O(ser_en), .RX_FRACTIONAL_OUT_O(frac),
		.RX_FRACTIONAL_EN_O(frac_en), .RX_OVERHEAD_OUT_O(oh), .RX_OVERHEAD_EN_O(oh_en),
		.LAPD1_DATA_O(l_d), .LAPD1_VALID_O(l_v), .LAPD1_READY_I(l_rdy),
		.LAPD1_IS_DL_O(l_dl), .LAPD1_IS_DE_O(l_de), .LAPD_OTHER_VALID_O(l_oth));
	rdlrs_lapd_model lapd (.clk_i(clk), .rst_n_i(rst_n), .data_i(l_d), .valid_i(l_v),
		.is_dl_i(l_dl), .is_de_i(l_de), .stall_i(stall), .ready_o(l_rdy));
	// 250 MHz core clock
	always #2 clk = ~clk;
	// Pin pulses counted per edge; a hang is cut off well past the run
	always @(posedge clk) begin
		cyc_cnt++;
		if (cyc_cnt == 20000) begin
			bad_count++;
			close_out();
		end
		if (rst_n && ser_en) begin
			ser_cnt++;
			ser_last = ser;
		end
		if (rst_n && oh_en) begin
			oh_cnt++;
			if (oh) oh_ones++;
		end
		if (rst_n && frac_en) begin
			frac_cnt++;
			if (frac) frac_ones++;
		end
		if (rst_n && l_oth) oth_seen = 1'b1;
	end
	// ****************************************************************
	// Bus and stream tasks
	// ****************************************************************
	// One classic cycle; only the bench timeout ends a wait for a dead slave
	task automatic wb(input logic w, input logic [11:0] a, input logic [31:0] d,
		output logic [31:0] q);
		@(posedge clk);
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= w;
		adr <= a;
		wdat <= d;
		do begin
			@(posedge clk);
		end while (ack !== 1'b1);
		q = rdat;
		cyc <= 1'b0;
		stb <= 1'b0;
		we <= 1'b0;
		@(posedge clk);
	endtask : wb
	task automatic set_sel(input logic [7:0] v);
		logic [31:0] q;
		wb(1'b1, `RDLRS_OFS_SELECT, {24'h0, v}, q);
	endtask : set_sel
	// One received bit for one cycle, with an idle cycle after
	task automatic send_bit(input logic dl, input logic de, input logic d,
		input logic f, input logic m);
		@(posedge clk);
		bv <= 1'b1;
		bdl <= dl;
		bde <= de;
		bd <= d;
		fs <= f;
		ms <= m;
		@(posedge clk);
		bv <= 1'b0;
		fs <= 1'b0;
		ms <= 1'b0;
	endtask : send_bit
	task automatic settle();
		repeat (4) @(posedge clk);
	endtask : settle
	// ****************************************************************
	// Scenarios
	// ****************************************************************
	// Reset value, unused bits reading zero, an unmapped read
	task automatic reg_test();
		logic [31:0] q;
		wb(1'b0, `RDLRS_OFS_SELECT, 32'h0, q);
		`CHK(q, 32'h0000_0000)
		set_sel(8'hFF);
		wb(1'b0, `RDLRS_OFS_SELECT, 32'h0, q);
		`CHK(q, 32'h0000_003F)
		wb(1'b0, 12'h200, 32'h0, q);
		`CHK(q, 32'h0000_0000)
	endtask : reg_test
	// A 12-frame multiframe; overhead pulses show which frames gave link bits
	task automatic bw_run(input rdlrs_fmt_e f, input logic [1:0] bw, input int exp,
		input int exp_ones);
		int o0, n0;
		fmt <= f;
		set_sel({2'b00, bw, 2'b00, 2'b10});
		o0 = oh_cnt;
		n0 = oh_ones;
		// Ones only in frames 1, 5, 9, so the ones count shows which phase was kept
		for (int i = 0; i < 12; i++) send_bit(1'b1, 1'b0, i[1:0] == 2'h0, 1'b1, i == 0);
		settle();
		`CHK(oh_cnt - o0, exp)
		`CHK(oh_ones - n0, exp_ones)
	endtask : bw_run
	task automatic bw_test();
		bw_run(RDLRS_FMT_ESF, 2'h0, 12, 3);
		bw_run(RDLRS_FMT_ESF, 2'h1, 3, 3);
		bw_run(RDLRS_FMT_ESF, 2'h2, 3, 0);
		bw_run(RDLRS_FMT_ESF, 2'h3, 12, 3);
		bw_run(RDLRS_FMT_SLC, 2'h1, 12, 3);
		bw_run(RDLRS_FMT_N, 2'h2, 12, 3);
		bw_run(RDLRS_FMT_T1DM, 2'h1, 12, 3);
		fmt <= RDLRS_FMT_ESF;
	endtask : bw_test
	// One link bit per destination code; a negative count skips that pin
	task automatic dl_case(input logic [1:0] c, input logic d, input int e_oh,
		input int e_lapd, input logic e_val);
		int s0, o0;
		set_sel({4'h0, 2'b00, c});
		lapd.got.delete();
		s0 = ser_cnt;
		o0 = oh_cnt;
		send_bit(1'b1, 1'b0, d, 1'b1, 1'b1);
		settle();
		`CHK(ser_cnt - s0, 1)
		`CHK(ser_last, e_val)
		if (e_oh >= 0) `CHK(oh_cnt - o0, e_oh)
		`CHK(lapd.got.size(), e_lapd)
		if (e_lapd == 1) `CHK(lapd.got[0], {2'b10, d})
	endtask : dl_case
	task automatic dl_test();
		dl_case(2'h0, 1'b0, 0, 1, 1'b0);
		dl_case(2'h2, 1'b1, 1, 0, 1'b1);
		dl_case(2'h3, 1'b0, -1, 0, 1'b1);
		dl_case(2'h1, 1'b1, 0, 1, 1'b1);
		`CHK(oth_seen, 1'b0)
	endtask : dl_test
	// One D/E slot bit per destination code
	task automatic de_case(input logic [1:0] c, input int e_ser, input int e_frac,
		input int e_lapd);
		int s0, f0, g0;
		set_sel({4'h0, c, 2'b00});
		lapd.got.delete();
		s0 = ser_cnt;
		f0 = frac_cnt;
		g0 = frac_ones;
		send_bit(1'b0, 1'b1, 1'b1, 1'b0, 1'b0);
		settle();
		if (e_ser >= 0) `CHK(ser_cnt - s0, e_ser)
		`CHK(frac_cnt - f0, e_frac)
		`CHK(frac_ones - g0, e_frac)
		`CHK(lapd.got.size(), e_lapd)
		if (e_lapd == 1) `CHK(lapd.got[0], 3'b011)
	endtask : de_case
	task automatic de_test();
		de_case(2'h0, 1, 0, 0);
		de_case(2'h1, 0, 0, 1);
		de_case(2'h3, 0, 1, 0);
		de_case(2'h2, 1, 0, 0);
	endtask : de_test
	// Stalled sink: ten link words overrun the buffer, then it drains
	task automatic fifo_test();
		logic [31:0] st;
		int n;
		set_sel(8'h00);
		stall <= 1'b1;
		lapd.got.delete();
		for (n = 0; n < 10; n++) send_bit(1'b1, 1'b0, n[0], 1'b1, 1'b1);
		settle();
		wb(1'b0, `RDLRS_OFS_STATUS, 32'h0, st);
		`CHK(st[2:1], 2'b01)
		stall <= 1'b0;
		n = 0;
		do begin
			@(posedge clk);
			n++;
		end while (l_v !== 1'b0 && n < 60);
		wb(1'b0, `RDLRS_OFS_STATUS, 32'h0, st);
		`CHK(st[2:1], 2'b10)
		`CHK(lapd.got.size() + st[31:16], 10)
		`CHK(lapd.got[0], 3'b100)
	endtask : fifo_test
	task automatic close_out();
		if (bad_count == 0 && cmp_count > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask : close_out
	// Reset for five cycles, then every scenario in turn
	initial begin
		repeat (5) @(posedge clk);
		rst_n <= 1'b1;
		reg_test();
		bw_test();
		dl_test();
		de_test();
		fifo_test();
		close_out();
	end
endmodule : test_rdlrs_top
